/* hdl/mbrs_frame_handler.sv */
/*
 * Slave frame handler of the serial parameter link: frames by idle gap,
 * checks address and crc, runs word read and word write on the parameter
 * store and queues the reply bytes in a transmit fifo.
 * Assumes a uart outside that delivers whole bytes with rx_valid, gives a
 * pulse every half character time, and drains tx bytes with tx_ready.
 * The parameter store answers par_rdata, par_never_mod and par_run_lock
 * from par_addr within one clock and holds them while par_addr stands.
 */
`timescale 1ns/1ns
`include "mbrs_defines.svh"

////////////////////////////////////////////////////////////////////////////
// Behaviour
// - only word access: 0x03 reads words, 0x06 writes one word
// - any other command is refused as an unsupported function
// - one read fetches one up to twelve consecutive words
// - bad lengths (from four bytes up), counts, addresses or commands and failed accesses get an exception reply; crc errors and shorter frames get none
// - frames start and end after 3.5 character times of silence
// - first byte is slave address 1 to 247, zero is broadcast
// - parameter address follows the command, high byte first
// - read requests carry a word count, high byte first, one is one word
// - a write has no count and changes exactly one word
// - data words travel high byte first, then low byte
// - every frame ends in a 16-bit crc over all earlier bytes
// - receiver recomputes the crc; a mismatch is a transmission error
// - the crc is preset to all ones at each frame start
// - only the eight data bits of each character enter the crc
// - per byte: xor in, eight right shifts, conditional polynomial xor
// - the crc is sent low byte first, then high byte
// - high address byte picks group F, A or U, low byte the parameter
// - the read-only monitor group refuses writes
// - writes to never-modifiable or run-locked parameters are refused
// - groups F0 to FE persist; alias 0x0000-0x0EFF writes RAM only
// - broadcast requests are executed but never answered; broadcast reads are dropped without a par_rd strobe
////////////////////////////////////////////////////////////////////////////

module mbrs_frame_handler (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// configuration
	input  wire logic [7:0]  my_addr,
	input  wire logic        running,
	// received bytes and line timing
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_valid,
	input  wire logic        half_char_tick,
	// bytes to transmit
	output logic      [7:0]  tx_data,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	// parameter store
	output logic      [15:0] par_addr,
	output logic             par_ram_only,
	output logic             par_rd,
	output logic             par_wr,
	output logic      [15:0] par_wdata,
	input  wire logic [15:0] par_rdata,
	input  wire logic        par_never_mod,
	input  wire logic        par_run_lock
);

	mbrs_pkg::mbrs_regs_s r_reg;
	mbrs_pkg::mbrs_regs_s r_next;

	logic [15:0] crc_rx_in;
	logic [15:0] crc_rx_nx;
	logic [15:0] crc_tx_nx;
	logic [7:0]  tx_byte;
	logic        push;
	logic        fifo_in_ready;

	logic [7:0]  b_adr;
	logic [7:0]  b_cmd;
	logic [7:0]  b_ahi;
	logic [7:0]  b_alo;
	logic [15:0] b_num;
	logic        bcast;
	logic        mine;
	logic        crc_ok;
	logic        map_ok;
	logic        alias_ram;
	logic        mon_ro;
	logic        len_ok;
	logic [7:0]  chk_code;
	logic [15:0] eff_addr;
	logic [2:0]  hdr_last;

	////////////////////////////////////////////////////////////////////////
	// crc steppers, one for each direction

	// preset while hunting, so the first byte starts from all ones
	assign crc_rx_in = (r_reg.st == mbrs_pkg::ST_HUNT) ?
		`MBRS_CRC_INIT : r_reg.crc_rx;

	// only the received data byte goes in, never framing bits
	mbrs_crc u_crc_rx (
		.crc_in  (crc_rx_in),
		.data    (rx_data),
		.crc_out (crc_rx_nx)
	);

	mbrs_crc u_crc_tx (
		.crc_in  (r_reg.crc_tx),
		.data    (tx_byte),
		.crc_out (crc_tx_nx)
	);

	////////////////////////////////////////////////////////////////////////
	// transmit buffer; a stalled uart stalls the reply generator

	mbrs_fifo #(
		.WIDTH (`MBRS_FIFO_WIDTH),
		.DEPTH (`MBRS_FIFO_DEPTH),
		.AW    (`MBRS_FIFO_AW)
	) u_tx_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.in_data   (tx_byte),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.out_data  (tx_data),
		.out_valid (tx_valid),
		.out_ready (tx_ready)
	);

	////////////////////////////////////////////////////////////////////////
	// request decode from the receive buffer

	// fields in arrival order, multi-byte fields high byte first
	always_comb begin
		b_adr = r_reg.rxb[0];
		b_cmd = r_reg.rxb[1];
		b_ahi = r_reg.rxb[2];
		b_alo = r_reg.rxb[3];
		b_num = {r_reg.rxb[4], r_reg.rxb[5]};
	end

	// a good frame including its own crc leaves a zero remainder
	assign crc_ok = r_reg.crc_rx == 16'h0000;
	assign bcast  = b_adr == `MBRS_BCAST_ADDR;
	assign mine   = b_adr == my_addr;
	assign len_ok = r_reg.cnt == `MBRS_FRAME_LEN;

	// high byte selects the group, low byte the parameter
	always_comb begin
		alias_ram = b_ahi <= `MBRS_HI_RAM_LAST;
		map_ok    = (b_ahi >= `MBRS_HI_F_FIRST) ||
			(b_ahi[7:4] == `MBRS_HI_A_NIB) ||
			(b_ahi[7:4] == `MBRS_HI_U_NIB) || alias_ram;
		mon_ro    = b_ahi == `MBRS_HI_MON_RO;
		eff_addr  = {b_ahi | (alias_ram ? `MBRS_HI_F_FIRST : 8'h00),
			b_alo};
	end

	// exception code of a request; the store's own locks come later
	always_comb begin
		if (b_cmd == `MBRS_CMD_RD) begin
			if (!len_ok || b_num == 16'h0000 ||
				b_num > `MBRS_MAX_WORDS) begin
				chk_code = `MBRS_EXC_VALUE;
			end else if (!map_ok) begin
				chk_code = `MBRS_EXC_ADDR;
			end else begin
				chk_code = `MBRS_EXC_NONE;
			end
		end else if (b_cmd == `MBRS_CMD_WR) begin
			if (!len_ok) begin
				chk_code = `MBRS_EXC_VALUE;
			end else if (!map_ok || mon_ro) begin
				chk_code = `MBRS_EXC_ADDR;
			end else begin
				chk_code = `MBRS_EXC_NONE;
			end
		end else begin
			chk_code = `MBRS_EXC_FUNC;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reply byte selection

	// error and read replies have a three byte head, a write echoes six
	assign hdr_last = (r_reg.err || r_reg.rd) ? 3'h2 : 3'h5;

	always_comb begin
		tx_byte = r_reg.rxb[r_reg.idx];
		if (r_reg.st == mbrs_pkg::ST_CRC_OUT) begin
			tx_byte = r_reg.idx[0] ? r_reg.crc_tx[15:8] :
				r_reg.crc_tx[7:0];
		end else if (r_reg.st == mbrs_pkg::ST_WORD_DATA) begin
			tx_byte = r_reg.lo ? par_rdata[7:0] : par_rdata[15:8];
		end else if (r_reg.err && r_reg.idx == 3'h1) begin
			tx_byte = b_cmd | `MBRS_EXC_MARK;
		end else if (r_reg.err && r_reg.idx == 3'h2) begin
			tx_byte = r_reg.code;
		end else if (r_reg.rd && r_reg.idx == 3'h2) begin
			tx_byte = {b_num[6:0], 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		r_next = r_reg;
		push   = 1'b0;
		r_next.par_rd = 1'b0;
		r_next.par_wr = 1'b0;

		// idle time since the last byte, saturating at the gap
		if (rx_valid) begin
			r_next.gap = 3'h0;
		end else if (half_char_tick && r_reg.gap != `MBRS_GAP_HALF) begin
			r_next.gap = r_reg.gap + 3'h1;
		end

		unique case (r_reg.st)
			// bytes seen without a full gap before them are ignored
			mbrs_pkg::ST_HUNT: begin
				if (rx_valid && r_reg.gap == `MBRS_GAP_HALF) begin
					r_next.rxb[0] = rx_data;
					r_next.cnt    = 4'h1;
					r_next.crc_rx = crc_rx_nx;
					r_next.st     = mbrs_pkg::ST_RECV;
				end
			end
			// over-long frames keep counting so they fail the length test
			mbrs_pkg::ST_RECV: begin
				if (rx_valid) begin
					if (r_reg.cnt < `MBRS_FRAME_LEN) begin
						r_next.rxb[r_reg.cnt[2:0]] = rx_data;
					end
					if (r_reg.cnt != 4'hf) begin
						r_next.cnt = r_reg.cnt + 4'h1;
					end
					r_next.crc_rx = crc_rx_nx;
				end else if (r_reg.gap == `MBRS_GAP_HALF) begin
					r_next.st = mbrs_pkg::ST_CHECK;
				end
			end
			// drop, refuse or execute
			mbrs_pkg::ST_CHECK: begin
				if (!crc_ok || !(bcast || mine) ||
					r_reg.cnt < `MBRS_MIN_LEN) begin
					r_next.st = mbrs_pkg::ST_HUNT;
				end else begin
					r_next.code  = chk_code;
					r_next.err   = chk_code != `MBRS_EXC_NONE;
					r_next.rd    = b_cmd == `MBRS_CMD_RD;
					r_next.words = b_num[3:0];
					r_next.idx   = 3'h0;
					r_next.lo    = 1'b0;
					r_next.crc_tx       = `MBRS_CRC_INIT;
					r_next.par_addr     = eff_addr;
					r_next.par_ram_only = alias_ram;
					r_next.par_wdata    = b_num;
					if (chk_code != `MBRS_EXC_NONE) begin
						r_next.st = bcast ? mbrs_pkg::ST_HUNT :
							mbrs_pkg::ST_HEAD;
					end else if (b_cmd == `MBRS_CMD_RD) begin
						r_next.st = bcast ? mbrs_pkg::ST_HUNT :
							mbrs_pkg::ST_HEAD;
					end else begin
						r_next.st = mbrs_pkg::ST_WR_EXEC;
					end
				end
			end
			// store attributes are valid now that par_addr has stood
			mbrs_pkg::ST_WR_EXEC: begin
				if (par_never_mod || (par_run_lock && running)) begin
					r_next.err  = 1'b1;
					r_next.code = `MBRS_EXC_LOCKED;
				end else begin
					r_next.par_wr = 1'b1;
				end
				r_next.st = bcast ? mbrs_pkg::ST_HUNT :
					mbrs_pkg::ST_HEAD;
			end
			// address, command and the rest of the head
			mbrs_pkg::ST_HEAD: begin
				push = fifo_in_ready;
				if (fifo_in_ready) begin
					r_next.crc_tx = crc_tx_nx;
					if (r_reg.idx == hdr_last) begin
						r_next.idx = 3'h0;
						r_next.st  = (r_reg.rd && !r_reg.err) ?
							mbrs_pkg::ST_WORD_ADDR : mbrs_pkg::ST_CRC_OUT;
					end else begin
						r_next.idx = r_reg.idx + 3'h1;
					end
				end
			end
			// strobe the read of the word now addressed
			mbrs_pkg::ST_WORD_ADDR: begin
				r_next.par_rd = 1'b1;
				r_next.st     = mbrs_pkg::ST_WORD_DATA;
			end
			// high byte then low byte, then on to the next address
			mbrs_pkg::ST_WORD_DATA: begin
				push = fifo_in_ready;
				if (fifo_in_ready) begin
					r_next.crc_tx = crc_tx_nx;
					r_next.lo     = !r_reg.lo;
					if (r_reg.lo) begin
						r_next.words    = r_reg.words - 4'h1;
						r_next.par_addr = r_reg.par_addr + 16'h0001;
						r_next.st = (r_reg.words == 4'h1) ?
							mbrs_pkg::ST_CRC_OUT : mbrs_pkg::ST_WORD_ADDR;
					end
				end
			end
			// crc low byte, then high byte; the crc itself is not folded
			mbrs_pkg::ST_CRC_OUT: begin
				push = fifo_in_ready;
				if (fifo_in_ready) begin
					if (r_reg.idx[0]) begin
						r_next.idx = 3'h0;
						r_next.st  = mbrs_pkg::ST_HUNT;
					end else begin
						r_next.idx = 3'h1;
					end
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// state register; the gap starts full so a first frame is accepted

	always_ff @(posedge clk) begin
		if (!rstn) begin
			r_reg <= '0;
			r_reg.st     <= mbrs_pkg::ST_HUNT;
			r_reg.gap    <= `MBRS_GAP_HALF;
			r_reg.crc_rx <= `MBRS_CRC_INIT;
			r_reg.crc_tx <= `MBRS_CRC_INIT;
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// store outputs straight from the state register

	assign par_addr     = r_reg.par_addr;
	assign par_ram_only = r_reg.par_ram_only;
	assign par_rd       = r_reg.par_rd;
	assign par_wr       = r_reg.par_wr;
	assign par_wdata    = r_reg.par_wdata;

endmodule : mbrs_frame_handler

/* hdl/mbrs_defines.svh */
/*
 * Constants of the serial parameter frame handler: frame layout, command
 * codes, exception codes, crc constants and the address map.
 * Assumes inclusion by bare name from every design file that needs them.
 */
`ifndef MBRS_DEFINES_SVH
`define MBRS_DEFINES_SVH

// line idle gap, in half character times (3.5 characters)
`define MBRS_GAP_HALF     3'h7
// request frames with a known command are always eight bytes
`define MBRS_FRAME_LEN    4'h8
`define MBRS_MIN_LEN      4'h4
`define MBRS_MAX_WORDS    16'h000c
`define MBRS_BCAST_ADDR   8'h00
// command codes and the exception mark
`define MBRS_CMD_RD       8'h03
`define MBRS_CMD_WR       8'h06
`define MBRS_EXC_MARK     8'h80
// exception codes
`define MBRS_EXC_NONE     8'h00
`define MBRS_EXC_FUNC     8'h01
`define MBRS_EXC_ADDR     8'h02
`define MBRS_EXC_VALUE    8'h03
`define MBRS_EXC_LOCKED   8'h04
// crc
`define MBRS_CRC_INIT     16'hffff
`define MBRS_CRC_POLY     16'ha001
// address map, high byte of the parameter address
`define MBRS_HI_F_FIRST   8'hf0
`define MBRS_HI_A_NIB     4'ha
`define MBRS_HI_U_NIB     4'h7
`define MBRS_HI_MON_RO    8'h70
`define MBRS_HI_RAM_LAST  8'h0e
// transmit buffer
`define MBRS_FIFO_WIDTH   8
`define MBRS_FIFO_DEPTH   16
`define MBRS_FIFO_AW      4

`endif

/* hdl/mbrs_pkg.sv */
/*
 * Types of the serial parameter frame handler: state codes and the
 * packed state record of the main module.
 * Assumes nothing of its surroundings.
 */
package mbrs_pkg;

	// gray codes along hunt, receive, check, execute, reply
	typedef enum logic [2:0] {
		ST_HUNT      = 3'h0,
		ST_RECV      = 3'h1,
		ST_CHECK     = 3'h3,
		ST_WR_EXEC   = 3'h2,
		ST_HEAD      = 3'h6,
		ST_WORD_ADDR = 3'h7,
		ST_WORD_DATA = 3'h5,
		ST_CRC_OUT   = 3'h4
	} mbrs_state_e;

	typedef struct packed {
		mbrs_state_e     st;
		logic [2:0]      gap;
		logic [3:0]      cnt;
		logic [7:0][7:0] rxb;
		logic [15:0]     crc_rx;
		logic [15:0]     crc_tx;
		logic [2:0]      idx;
		logic            err;
		logic [7:0]      code;
		logic            rd;
		logic [3:0]      words;
		logic            lo;
		logic [15:0]     par_addr;
		logic            par_ram_only;
		logic            par_rd;
		logic            par_wr;
		logic [15:0]     par_wdata;
	} mbrs_regs_s;

endpackage : mbrs_pkg

/* hdl/mbrs_crc.sv */
/*
 * One byte step of the frame crc, purely combinational.
 * Assumes the caller holds the running crc and presets it per frame.
 */
`timescale 1ns/1ns
`include "mbrs_defines.svh"

module mbrs_crc (
	// running value in
	input  wire logic [15:0] crc_in,
	// one data byte, framing bits never reach here
	input  wire logic [7:0]  data,
	// value after the byte
	output logic      [15:0] crc_out
);

	// xor the byte in, then eight right shifts with conditional poly
	always_comb begin
		crc_out = crc_in ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			if (crc_out[0]) begin
				crc_out = (crc_out >> 1) ^ `MBRS_CRC_POLY;
			end else begin
				crc_out = crc_out >> 1;
			end
		end
	end

endmodule : mbrs_crc

/* hdl/mbrs_fifo.sv */
/*
 * Synchronous fifo with valid and ready on both sides.
 * Assumes one clock; in_ready and out_valid are registered.
 */
`timescale 1ns/1ns

module mbrs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// filling side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	// draining side
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW:0]      cnt_reg;
	logic [AW:0]      cnt_next;
	logic             put;
	logic             take;

	////////////////////////////////////////////////////////////////////////
	// handshakes and fill level
	assign put  = in_valid && in_ready;
	assign take = out_valid && out_ready;
	assign out_data = mem[rd_reg];

	always_comb begin
		cnt_next = cnt_reg + (AW+1)'(put) - (AW+1)'(take);
	end

	// flags are registered from the next level, so full and empty are exact
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wr_reg    <= '0;
			rd_reg    <= '0;
			cnt_reg   <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			if (put) begin
				mem[wr_reg] <= in_data;
				wr_reg      <= wr_reg + 1'b1;
			end
			if (take) begin
				rd_reg <= rd_reg + 1'b1;
			end
			cnt_reg   <= cnt_next;
			in_ready  <= cnt_next != (AW+1)'(DEPTH);
			out_valid <= cnt_next != '0;
		end
	end

endmodule : mbrs_fifo

/* verif/mbrs_master_model.sv */
/*
 * Master side of the serial link: sends framed requests with crc and
 * collects the reply bytes, promptly or with a stalled sink.
 * Assumes the handler's clock; half_char_tick is made here.
 */
`timescale 1ns/1ns

module mbrs_master_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// request bytes and line timing
	output logic      [7:0] rx_data,
	output logic            rx_valid,
	output logic            half_char_tick,
	// reply bytes
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	logic [1:0] div;
	logic       stall;
	logic [7:0] got[$];

	////////////////////////////////////////////////////////////////////////
	// crc of one message, bit by bit
	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
			end
		end
		return c;
	endfunction : crc16

	// quiet line at time zero
	initial begin
		div = 2'h0;
		stall = 1'b0;
		rx_data = 8'h00;
		rx_valid = 1'b0;
		half_char_tick = 1'b0;
		tx_ready = 1'b0;
	end

	// tick every four clocks; a stalled sink takes one byte in four
	always @(posedge clk) begin
		div            <= div + 2'h1;
		half_char_tick <= (div == 2'h3);
		tx_ready       <= rstn && (!stall || div == 2'h0);
		if (tx_valid && tx_ready) begin
			got.push_back(tx_data);
		end
	end

	// one request: quiet lead-in, bytes two ticks apart, crc low first
	task automatic send(input logic [7:0] b[$], input logic bad);
		logic [15:0] c;
		c = crc16(b) ^ {15'h0000, bad};
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
		repeat (32) @(posedge clk);
		foreach (b[i]) begin
			rx_data  <= b[i];
			rx_valid <= 1'b1;
			@(posedge clk);
			rx_data  <= ~b[i]; // released line must not keep the byte
			rx_valid <= 1'b0;
			repeat (7) @(posedge clk);
		end
		repeat (40) @(posedge clk);
	endtask : send
endmodule : mbrs_master_model

/* verif/mbrs_frame_handler_asserts.sv */
/*
 * Concurrent checks on the frame handler's ports, bound to the handler.
 * Assumes the bench's tick of one pulse per four clocks.
 */
`timescale 1ns/1ns

module mbrs_frame_handler_asserts (
	// clock and reset
	input wire logic        clk,
	input wire logic        rstn,
	// configuration and receive side
	input wire logic [7:0]  my_addr,
	input wire logic        running,
	input wire logic [7:0]  rx_data,
	input wire logic        rx_valid,
	input wire logic        half_char_tick,
	// transmit side
	input wire logic [7:0]  tx_data,
	input wire logic        tx_valid,
	input wire logic        tx_ready,
	// parameter store
	input wire logic [15:0] par_addr,
	input wire logic        par_ram_only,
	input wire logic        par_rd,
	input wire logic        par_wr,
	input wire logic [15:0] par_wdata,
	input wire logic [15:0] par_rdata,
	input wire logic        par_never_mod,
	input wire logic        par_run_lock
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	////////////////////////////////////////////////////////////////////////
	// store strobes
	rd_single_a: assert property (par_rd |=> !par_rd)
		else $error("word read strobe longer than a cycle");
	rd_feeds_tx_a: assert property (par_rd |-> ##[1:4] tx_valid)
		else $error("read word never reached the reply");
	wr_single_a: assert property (par_wr |=> !par_wr [*8])
		else $error("more than one word written");
	ro_group_a: assert property (par_wr |-> par_addr[15:8] != 8'h70)
		else $error("write reached the read-only group");
	locked_wr_a: assert property (par_wr |->
		!par_never_mod && !(par_run_lock && running))
		else $error("write reached a locked parameter");
	ram_alias_a: assert property (par_ram_only |->
		par_addr[15:8] >= 8'hf0 && par_addr[15:8] <= 8'hfe)
		else $error("ram alias mapped outside groups f0 to fe");

	// transmit stream
	tx_hold_a: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data))
		else $error("reply byte changed before it was taken");
	quiet_rx_a: assert property (rx_valid && !tx_valid |=>
		!tx_valid [*8])
		else $error("reply started inside the idle gap");

	// main scenarios reached
	ram_write_c: cover property (par_wr && par_ram_only);
	stall_c: cover property (tx_valid && !tx_ready);
	multi_read_c: cover property (par_rd ##[2:8] par_rd);
endmodule : mbrs_frame_handler_asserts

bind mbrs_frame_handler mbrs_frame_handler_asserts u_asserts (
	.clk(clk), .rstn(rstn), .my_addr(my_addr), .running(running),
	.rx_data(rx_data), .rx_valid(rx_valid),
	.half_char_tick(half_char_tick), .tx_data(tx_data),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .par_addr(par_addr),
	.par_ram_only(par_ram_only), .par_rd(par_rd), .par_wr(par_wr),
	.par_wdata(par_wdata), .par_rdata(par_rdata),
	.par_never_mod(par_never_mod), .par_run_lock(par_run_lock)
);

/* verif/mbrs_frame_handler_test.sv */
/*
 * Self-checking bench of the frame handler: master model on the line,
 * a small parameter store answering from the address.
 * Assumes the master model and the bound checker are compiled first.
 */
`timescale 1ns/1ns

module mbrs_frame_handler_test;
	logic        clk;
	logic        rstn;
	logic        running;
	logic [7:0]  rx_data;
	logic        rx_valid;
	logic        half_char_tick;
	logic [7:0]  tx_data;
	logic        tx_valid;
	logic        tx_ready;
	logic [15:0] par_addr;
	logic        par_ram_only;
	logic        par_rd;
	logic        par_wr;
	logic [15:0] par_wdata;
	logic [15:0] par_wdata_seen;
	logic [15:0] wr_addr;
	logic        wr_ram;
	int          wr_cnt = 0;
	int          rd_cnt = 0;
	int          n_errors;
	int          tests_run;
	int          cyc = 0;
	logic [7:0]  none[$];

	mbrs_master_model m (.clk(clk), .rstn(rstn), .rx_data(rx_data),
		.rx_valid(rx_valid), .half_char_tick(half_char_tick),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

	// store: data from address, f0ff never writable, f0fe run-locked
	mbrs_frame_handler dut (.clk(clk), .rstn(rstn), .my_addr(8'h11),
		.running(running), .rx_data(rx_data), .rx_valid(rx_valid),
		.half_char_tick(half_char_tick), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .par_addr(par_addr),
		.par_ram_only(par_ram_only), .par_rd(par_rd), .par_wr(par_wr),
		.par_wdata(par_wdata), .par_rdata(par_addr ^ 16'h5a5a),
		.par_never_mod(par_addr == 16'hf0ff),
		.par_run_lock(par_addr == 16'hf0fe));

	////////////////////////////////////////////////////////////////////////
	always #50 clk = ~clk;

	// strobe log and the cycle count that the hang guard watches
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (par_rd === 1'b1) begin
			rd_cnt <= rd_cnt + 1;
		end
		if (par_wr === 1'b1) begin
			wr_cnt         <= wr_cnt + 1;
			wr_addr        <= par_addr;
			par_wdata_seen <= par_wdata;
			wr_ram         <= par_ram_only;
		end
	end

	task automatic chk16(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk16

	task automatic chk_n(input string what, input int exp, input int got);
		tests_run++;
		if (got != exp) begin
			n_errors++;
			$display("[FAIL] %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chk_n

	// one request, then the whole reply (crc appended) byte by byte
	task automatic xact(input string what, input logic [7:0] req[$],
		input logic [7:0] exp[$], input logic bad);
		logic [15:0] c;
		int          w;
		m.got.delete();
		m.send(req, bad);
		if (exp.size() > 0) begin
			c = m.crc16(exp);
			exp.push_back(c[7:0]);
			exp.push_back(c[15:8]);
		end
		w = 0;
		while (m.got.size() < exp.size() && w < 600) begin
			@(posedge clk);
			w++;
		end
		repeat (40) @(posedge clk);
		chk_n({what, " length"}, exp.size(), m.got.size());
		foreach (exp[i]) begin
			if (i < m.got.size()) begin
				chk16(what, {8'h00, exp[i]}, {8'h00, m.got[i]});
			end
		end
	endtask : xact

	task automatic t_read();
		logic [7:0] e[$];
		int         n;
		xact("read one", '{8'h11, 8'h03, 8'hf3, 8'h0c, 8'h00, 8'h01},
			'{8'h11, 8'h03, 8'h02, 8'ha9, 8'h56}, 1'b0);
		e = '{8'h11, 8'h03, 8'h18};
		for (int k = 0; k < 12; k++) begin
			e.push_back(8'hfa);
			e.push_back(8'(k) ^ 8'h5a);
		end
		m.stall <= 1'b1;
		n = rd_cnt;
		xact("read twelve", '{8'h11, 8'h03, 8'ha0, 8'h00, 8'h00, 8'h0c},
			e, 1'b0);
		m.stall <= 1'b0;
		chk_n("read strobes", n + 12, rd_cnt);
		xact("read thirteen", '{8'h11, 8'h03, 8'ha0, 8'h00, 8'h00, 8'h0d},
			'{8'h11, 8'h83, 8'h03}, 1'b0);
		xact("read zero", '{8'h11, 8'h03, 8'ha0, 8'h00, 8'h00, 8'h00},
			'{8'h11, 8'h83, 8'h03}, 1'b0);
		xact("read unmapped", '{8'h11, 8'h03, 8'h20, 8'h00, 8'h00, 8'h01},
			'{8'h11, 8'h83, 8'h02}, 1'b0);
		$display("test read done");
	endtask : t_read

	task automatic t_write();
		logic [7:0] q[$];
		q = '{8'h11, 8'h06, 8'h01, 8'h05, 8'h12, 8'h34};
		xact("write ram", q, q, 1'b0);
		chk16("ram address", 16'hf105, wr_addr);
		chk16("ram flag", 16'h0001, {15'h0000, wr_ram});
		chk16("ram data", 16'h1234, par_wdata_seen);
		q = '{8'h11, 8'h06, 8'hf1, 8'h05, 8'h56, 8'h78};
		xact("write eeprom", q, q, 1'b0);
		chk16("eeprom data", 16'h5678, par_wdata_seen);
		chk16("eeprom flag", 16'h0000, {15'h0000, wr_ram});
		$display("test write done");
	endtask : t_write

	task automatic t_refuse();
		logic [7:0] q[$];
		int         n;
		n = wr_cnt;
		xact("write monitor", '{8'h11, 8'h06, 8'h70, 8'h03, 8'h00, 8'h01},
			'{8'h11, 8'h86, 8'h02}, 1'b0);
		xact("write fixed", '{8'h11, 8'h06, 8'hf0, 8'hff, 8'h00, 8'h01},
			'{8'h11, 8'h86, 8'h04}, 1'b0);
		xact("write short", '{8'h11, 8'h06, 8'hf1, 8'h05, 8'h12},
			'{8'h11, 8'h86, 8'h03}, 1'b0);
		running <= 1'b1;
		xact("write locked", '{8'h11, 8'h06, 8'hf0, 8'hfe, 8'h00, 8'h01},
			'{8'h11, 8'h86, 8'h04}, 1'b0);
		running <= 1'b0;
		q = '{8'h11, 8'h06, 8'hf0, 8'hfe, 8'h00, 8'h02};
		xact("write stopped", q, q, 1'b0);
		chk_n("write strobes", n + 1, wr_cnt);
		$display("test refuse done");
	endtask : t_refuse

	task automatic t_odd();
		logic [7:0] cmds[6];
		cmds = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h0f, 8'h10};
		foreach (cmds[i]) begin
			xact("other command", '{8'h11, cmds[i], 8'hf0, 8'h00, 8'h00,
				8'h01}, '{8'h11, cmds[i] | 8'h80, 8'h01}, 1'b0);
		end
		$display("test commands done");
	endtask : t_odd

	task automatic t_silent();
		int n;
		n = wr_cnt;
		xact("broadcast", '{8'h00, 8'h06, 8'hf2, 8'h00, 8'hab, 8'hcd},
			none, 1'b0);
		chk_n("broadcast strobe", n + 1, wr_cnt);
		chk16("broadcast data", 16'habcd, par_wdata_seen);
		xact("foreign", '{8'h12, 8'h03, 8'hf3, 8'h0c, 8'h00, 8'h01},
			none, 1'b0);
		xact("bad crc", '{8'h11, 8'h06, 8'hf3, 8'h0c, 8'h00, 8'h01},
			none, 1'b1);
		chk_n("bad crc strobe", n + 1, wr_cnt);
		$display("test silent done");
	endtask : t_silent

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up

	// reset, then every scenario in turn
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		running = 1'b0;
		n_errors = 0;
		tests_run = 0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		// scenarios race the hang guard; a timeout counts as a mismatch
		fork
			begin
				t_read();
				t_write();
				t_refuse();
				t_odd();
				t_silent();
			end
			begin
				wait (cyc == 20000);
				n_errors++;
			end
		join_any
		wrap_up();
	end
endmodule : mbrs_frame_handler_test
